// [src/lsb_exec_top.sv]
/*
 * holds: execution unit for branches on V and I, loads, stores, program
 * memory access, stack, I/O bit set/clear and shifts, with AXI4-Lite regs.
 * assumes: memories and I/O space answer combinationally in the strobe cycle.
 */
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "lsb_cfg.svh"

module lsb_exec_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [15:0]      dm_addr,
    output logic             dm_re,
    output logic             dm_we,
    output logic [7:0]       dm_wdata,
    input  wire logic [7:0]  dm_rdata,
    output logic [15:0]      pm_addr,
    output logic             pm_re,
    output logic             pm_we,
    output logic [15:0]      pm_wdata,
    input  wire logic [7:0]  pm_rdata,
    output logic [5:0]       io_addr,
    output logic             io_re,
    output logic             io_we,
    output logic [7:0]       io_wdata,
    input  wire logic [7:0]  io_rdata
);

    // ****************************************
    // state
    // ****************************************
    lsb_pkg::lsb_state_t state_reg;
    logic [7:0]  gpr [0:31];
    logic [15:0] pc_reg;
    logic [15:0] sp_reg;
    logic [7:0]  sreg_reg;
    logic [13:0] instr_reg;
    logic [15:0] oper_reg;
    logic [4:0]  gsel_reg;
    logic [3:0]  cnt_reg;
    logic [3:0]  len_reg;
    logic [3:0]  last_reg;
    logic        done_reg;
    logic        err_reg;
    logic [7:0]  aw_addr_reg;
    logic        aw_have_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        w_have_reg;

    // ****************************************
    // instruction decode
    // ****************************************
    wire lsb_pkg::lsb_op_t   op   = lsb_pkg::lsb_op_t'(instr_reg[4:0]);
    wire lsb_pkg::lsb_mode_t mode = lsb_pkg::lsb_mode_t'(instr_reg[13:12]);
    wire [4:0]  rsel = instr_reg[9:5];
    wire [1:0]  psel = instr_reg[11:10];
    wire [5:0]  q    = oper_reg[5:0];
    wire [5:0]  port = oper_reg[5:0];
    wire [2:0]  bsel = oper_reg[10:8];
    wire        busy = (state_reg == lsb_pkg::st_run);

    logic is_br, is_ld, is_st, is_ind, is_disp, is_dir, is_lpm, is_sh;
    always_comb begin
        {is_br, is_ld, is_st, is_ind, is_disp, is_dir, is_lpm, is_sh} = 8'h00;
        case (op)
            lsb_pkg::op_branch_no_overflow,
            lsb_pkg::op_branch_irq_on,
            lsb_pkg::op_branch_irq_off:     is_br = 1'b1;
            lsb_pkg::op_mem_read_ind:       {is_ld, is_ind} = 2'h3;
            lsb_pkg::op_read_with_offset:   {is_ld, is_disp} = 2'h3;
            lsb_pkg::op_direct_read:        {is_ld, is_dir} = 2'h3;
            lsb_pkg::op_mem_write_ind:      {is_st, is_ind} = 2'h3;
            lsb_pkg::op_write_with_offset:  {is_st, is_disp} = 2'h3;
            lsb_pkg::op_direct_write:       {is_st, is_dir} = 2'h3;
            lsb_pkg::op_prog_mem_read_r0,
            lsb_pkg::op_prog_mem_read:      is_lpm = 1'b1;
            lsb_pkg::op_shift_left_logical,
            lsb_pkg::op_shift_right_logical,
            lsb_pkg::op_rotate_left_carry,
            lsb_pkg::op_rotate_right_carry: is_sh = 1'b1;
            default: ;
        endcase
    end

    wire is_spm  = (op == lsb_pkg::op_prog_mem_write);
    wire is_push = (op == lsb_pkg::op_push);
    wire is_pop  = (op == lsb_pkg::op_pop);
    wire is_sbi  = (op == lsb_pkg::op_io_bit_set);
    wire is_cbi  = (op == lsb_pkg::op_io_bit_clear);
    wire sh_left = (op == lsb_pkg::op_shift_left_logical) |
                   (op == lsb_pkg::op_rotate_left_carry);
    wire sh_rot  = (op == lsb_pkg::op_rotate_left_carry) |
                   (op == lsb_pkg::op_rotate_right_carry);

    // displaced forms exist only for the second and third pointer pairs
    wire legal = (instr_reg[4:0] <= 5'h13) &
                 !((is_ind | is_disp) & (psel == 2'h3)) &
                 !(is_disp & (psel == 2'h0));

    wire taken = ((op == lsb_pkg::op_branch_no_overflow) &
                  !sreg_reg[`LSB_SR_V]) |
                 ((op == lsb_pkg::op_branch_irq_on) &
                  sreg_reg[`LSB_SR_I]) |
                 ((op == lsb_pkg::op_branch_irq_off) &
                  !sreg_reg[`LSB_SR_I]);

    // ****************************************
    // addressing
    // ****************************************
    wire [4:0]  plo  = is_lpm | is_spm ? `LSB_ZPTR_LO
                                       : `LSB_PTR_BASE + {2'h0, psel, 1'b0};
    wire [4:0]  phi  = plo + 5'h01;
    wire [15:0] ptr  = {gpr[phi], gpr[plo]};
    wire        pre  = is_ind & (mode == lsb_pkg::mode_pre_dec);
    wire        post = (is_ind | op == lsb_pkg::op_prog_mem_read) &
                       (mode == lsb_pkg::mode_post_inc);

    logic [15:0] ea;
    always_comb begin
        if (is_ind)
            ea = pre ? ptr - 16'h0001 : ptr;
        else if (is_disp)
            ea = ptr + {10'h000, q};
        else if (is_dir)
            ea = oper_reg;
        else if (is_push)
            ea = sp_reg;
        else if (is_pop)
            ea = sp_reg + 16'h0001;
        else
            ea = ptr;
    end

    logic [3:0] len;
    always_comb begin
        if (is_br)
            len = taken ? `LSB_CYC_BR_T : `LSB_CYC_BR_NT;
        else if (is_sh)
            len = `LSB_CYC_SH;
        else if (is_lpm)
            len = `LSB_CYC_LPM;
        else if (is_spm)
            len = `LSB_CYC_SPM;
        else
            len = `LSB_CYC_MEM;
    end

    // ****************************************
    // shifter and execute strobes
    // ****************************************
    logic [7:0] sh_res;
    logic       sh_c, sh_z, sh_n, sh_v;

    lsb_shift u_shift (
        .din  (gpr[rsel]),
        .cin  (sreg_reg[`LSB_SR_C]),
        .left (sh_left),
        .rot  (sh_rot),
        .dout (sh_res),
        .cout (sh_c),
        .zf   (sh_z),
        .nf   (sh_n),
        .vf   (sh_v)
    );

    wire x1    = busy & (cnt_reg == 4'h1);
    wire xfin  = busy & (cnt_reg == len_reg);
    wire rd_we = x1 & (is_ld | is_pop | is_lpm | is_sh);
    wire [4:0] rd_idx = (op == lsb_pkg::op_prog_mem_read_r0) ? 5'h00 : rsel;
    wire [7:0] rd_val = is_lpm ? pm_rdata : (is_sh ? sh_res : dm_rdata);
    wire ptr_we = x1 & (pre | post);
    wire [15:0] ptr_new = pre ? ea : ptr + 16'h0001;
    wire [7:0]  bmask = 8'h01 << bsel;

    // ****************************************
    // register bus decode
    // ****************************************
    wire aw_take = awvalid & awready;
    wire w_take  = wvalid & wready;
    wire ar_take = arvalid & arready;
    wire wr_do   = aw_have_reg & w_have_reg & !bvalid;
    wire [31:0] wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                         {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

    function automatic logic [31:0] reg_rd(input logic [7:0] a);
        case ({a[7:2], 2'b00})
            `LSB_OFF_STATUS: reg_rd = {20'h0_0000, last_reg, 5'h00,
                                       err_reg, done_reg, busy};
            `LSB_OFF_INSTR:  reg_rd = {18'h0_0000, instr_reg};
            `LSB_OFF_OPER:   reg_rd = {16'h0000, oper_reg};
            `LSB_OFF_PC:     reg_rd = {16'h0000, pc_reg};
            `LSB_OFF_SREG:   reg_rd = {24'h00_0000, sreg_reg};
            `LSB_OFF_SP:     reg_rd = {16'h0000, sp_reg};
            `LSB_OFF_GSEL:   reg_rd = {27'h000_0000, gsel_reg};
            `LSB_OFF_GDATA:  reg_rd = {24'h00_0000, gpr[gsel_reg]};
            default:         reg_rd = 32'h0000_0000;
        endcase
    endfunction : reg_rd

    wire [7:0]  wa  = {aw_addr_reg[7:2], 2'b00};
    wire        whit = (wa <= `LSB_OFF_GDATA);
    wire        rhit = ({araddr[7:2], 2'b00} <= `LSB_OFF_GDATA);
    wire [31:0] wv  = (reg_rd(aw_addr_reg) & ~wmask) | (wdata_reg & wmask);
    wire        sw  = wr_do & !busy;
    wire go    = wr_do & (wa == `LSB_OFF_CTRL) & wdata_reg[`LSB_CTRL_GO] &
                 wstrb_reg[0] & !busy;
    wire start = go & legal;
    wire st_w  = wr_do & (wa == `LSB_OFF_STATUS);
    wire clr_d = st_w & wv[`LSB_STAT_DONE];
    wire clr_e = st_w & wv[`LSB_STAT_ERR];

    // ****************************************
    // AXI4-Lite handshakes
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready     <= 1'b0;
            wready      <= 1'b0;
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            aw_addr_reg <= 8'h00;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            bvalid      <= 1'b0;
            bresp       <= `LSB_RESP_OK;
        end else begin
            awready <= awready ? !aw_take : (!aw_have_reg & !bvalid);
            wready  <= wready ? !w_take : (!w_have_reg & !bvalid);
            if (aw_take) begin
                aw_addr_reg <= awaddr;
                aw_have_reg <= 1'b1;
            end
            if (w_take) begin
                wdata_reg  <= wdata;
                wstrb_reg  <= wstrb;
                w_have_reg <= 1'b1;
            end
            if (wr_do) begin
                aw_have_reg <= 1'b0;
                w_have_reg  <= 1'b0;
                bvalid      <= 1'b1;
                bresp       <= whit ? `LSB_RESP_OK : `LSB_RESP_ERR;
            end else if (bvalid & bready)
                bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `LSB_RESP_OK;
        end else begin
            arready <= arready ? !ar_take : !rvalid;
            if (ar_take) begin
                rvalid <= 1'b1;
                rdata  <= reg_rd(araddr);
                rresp  <= rhit ? `LSB_RESP_OK : `LSB_RESP_ERR;
            end else if (rvalid & rready)
                rvalid <= 1'b0;
        end
    end

    // ****************************************
    // software-visible control registers
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr_reg <= 14'h0000;
            oper_reg  <= 16'h0000;
            gsel_reg  <= 5'h00;
            done_reg  <= 1'b0;
            err_reg   <= 1'b0;
        end else begin
            if (sw & (wa == `LSB_OFF_INSTR))
                instr_reg <= wv[13:0];
            if (sw & (wa == `LSB_OFF_OPER))
                oper_reg <= wv[15:0];
            if (sw & (wa == `LSB_OFF_GSEL))
                gsel_reg <= wv[4:0];
            done_reg <= xfin | (done_reg & !clr_d);
            err_reg  <= (go & !legal) | (err_reg & !clr_e);
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= lsb_pkg::st_idle;
            cnt_reg   <= 4'h0;
            len_reg   <= 4'h0;
            last_reg  <= 4'h0;
        end else begin
            case (state_reg)
                lsb_pkg::st_idle: if (start) begin
                    state_reg <= lsb_pkg::st_run;
                    cnt_reg   <= 4'h1;
                    len_reg   <= len;
                end
                lsb_pkg::st_run: if (xfin) begin
                    state_reg <= lsb_pkg::st_idle;
                    last_reg  <= len_reg;
                end else
                    cnt_reg <= cnt_reg + 4'h1;
                default: state_reg <= lsb_pkg::st_idle;
            endcase
        end
    end

    // ****************************************
    // memory and I/O strobes
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {dm_re, dm_we, pm_re, pm_we, io_re, io_we} <= 6'h00;
            dm_addr  <= 16'h0000;
            dm_wdata <= 8'h00;
            pm_addr  <= 16'h0000;
            pm_wdata <= 16'h0000;
            io_addr  <= 6'h00;
            io_wdata <= 8'h00;
        end else if (start) begin
            dm_re    <= is_ld | is_pop;
            dm_we    <= is_st | is_push;
            dm_addr  <= ea;
            dm_wdata <= gpr[rsel];
            pm_re    <= is_lpm;
            pm_we    <= is_spm;
            pm_addr  <= ptr;
            pm_wdata <= {gpr[1], gpr[0]};
            io_re    <= is_sbi | is_cbi;
            io_addr  <= port;
        end else if (x1) begin
            {dm_re, dm_we, pm_re, pm_we, io_re} <= 5'h00;
            io_we    <= is_sbi | is_cbi;
            io_wdata <= is_sbi ? io_rdata | bmask
                               : io_rdata & ~bmask;
        end else if (xfin)
            io_we <= 1'b0;
    end

    // ****************************************
    // register file, pointers, PC, SP, flags
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 32; i++)
                gpr[i] <= 8'h00;
        end else if (busy) begin
            if (ptr_we) begin
                gpr[plo] <= ptr_new[7:0];
                gpr[phi] <= ptr_new[15:8];
            end
            if (rd_we)
                gpr[rd_idx] <= rd_val;
        end else if (sw & (wa == `LSB_OFF_GDATA))
            gpr[gsel_reg] <= wv[7:0];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_reg   <= `LSB_PC_RST;
            sp_reg   <= `LSB_SP_RST;
            sreg_reg <= 8'h00;
        end else if (busy) begin
            if (x1 & is_push)
                sp_reg <= sp_reg - 16'h0001;
            if (x1 & is_pop)
                sp_reg <= ea;
            if (x1 & is_sh) begin
                sreg_reg[`LSB_SR_C] <= sh_c;
                sreg_reg[`LSB_SR_Z] <= sh_z;
                sreg_reg[`LSB_SR_N] <= sh_n;
                sreg_reg[`LSB_SR_V] <= sh_v;
            end
            if (xfin) begin
                if (is_br & taken)
                    pc_reg <= pc_reg + oper_reg + 16'h0001;
                else
                    pc_reg <= pc_reg + (is_dir ? 16'h0002 : 16'h0001);
            end
        end else if (sw) begin
            if (wa == `LSB_OFF_PC)
                pc_reg <= wv[15:0];
            if (wa == `LSB_OFF_SP)
                sp_reg <= wv[15:0];
            if (wa == `LSB_OFF_SREG)
                sreg_reg <= wv[7:0];
        end
    end

endmodule : lsb_exec_top

`default_nettype wire

// [src/lsb_cfg.svh]
/*
 * holds: register offsets, field positions, reset values and cycle counts
 * of the load/store/shift/branch execution block.
 * assumes: included by bare name from the block's design files.
 */
`ifndef LSB_CFG_SVH
`define LSB_CFG_SVH

// ****************************************
// register byte offsets
// ****************************************
`define LSB_OFF_CTRL    8'h00
`define LSB_OFF_STATUS  8'h04
`define LSB_OFF_INSTR   8'h08
`define LSB_OFF_OPER    8'h0C
`define LSB_OFF_PC      8'h10
`define LSB_OFF_SREG    8'h14
`define LSB_OFF_SP      8'h18
`define LSB_OFF_GSEL    8'h1C
`define LSB_OFF_GDATA   8'h20

// ****************************************
// field positions
// ****************************************
`define LSB_CTRL_GO     0
`define LSB_STAT_BUSY   0
`define LSB_STAT_DONE   1
`define LSB_STAT_ERR    2
`define LSB_SR_I        7
`define LSB_SR_V        3
`define LSB_SR_N        2
`define LSB_SR_Z        1
`define LSB_SR_C        0

// ****************************************
// reset values and fixed indices
// ****************************************
`define LSB_SP_RST      16'h00FF
`define LSB_PC_RST      16'h0000
`define LSB_PTR_BASE    5'h1A
`define LSB_ZPTR_LO     5'h1E
`define LSB_RESP_OK     2'h0
`define LSB_RESP_ERR    2'h2

// ****************************************
// cycle counts
// ****************************************
`define LSB_CYC_BR_NT   4'h1
`define LSB_CYC_BR_T    4'h2
`define LSB_CYC_MEM     4'h2
`define LSB_CYC_LPM     4'h3
`define LSB_CYC_SPM     4'h2
`define LSB_CYC_SH      4'h1

`endif

// [src/lsb_pkg.sv]
/*
 * holds: types of the load/store/shift/branch execution block.
 * assumes: compiled before the block's modules.
 */
package lsb_pkg;

    typedef enum logic [4:0] {
        op_branch_no_overflow, op_branch_irq_on, op_branch_irq_off,
        op_mem_read_ind, op_read_with_offset, op_direct_read,
        op_mem_write_ind, op_write_with_offset, op_direct_write,
        op_prog_mem_read_r0, op_prog_mem_read, op_prog_mem_write,
        op_push, op_pop, op_io_bit_set, op_io_bit_clear,
        op_shift_left_logical, op_shift_right_logical,
        op_rotate_left_carry, op_rotate_right_carry
    } lsb_op_t;

    typedef enum logic [1:0] {
        mode_plain, mode_post_inc, mode_pre_dec, mode_rsvd
    } lsb_mode_t;

    typedef enum logic {st_idle, st_run} lsb_state_t;

endpackage : lsb_pkg

// [src/lsb_shift.sv]
/*
 * holds: one-bit shifter and rotator through carry, with flag results.
 * assumes: purely combinational; the caller registers the results.
 */
`timescale 1ns/1ns
`default_nettype none

module lsb_shift (
    input  wire logic [7:0] din,
    input  wire logic       cin,
    input  wire logic       left,
    input  wire logic       rot,
    output logic      [7:0] dout,
    output logic            cout,
    output logic            zf,
    output logic            nf,
    output logic            vf
);

    wire fill = rot & cin;

    assign dout = left ? {din[6:0], fill} : {fill, din[7:1]};
    assign cout = left ? din[7] : din[0];
    assign zf   = (dout == 8'h00);
    assign nf   = dout[7];
    assign vf   = dout[7] ^ cout;

endmodule : lsb_shift

`default_nettype wire

// [verif/lsb_chk.sv]
/* holds: port assertions for the execution unit.
   assumes: bound to lsb_exec_top from the testbench top file. */
`timescale 1ns/1ns
`default_nettype none
module lsb_chk (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       awready,
    input wire logic       wready,
    input wire logic       bvalid,
    input wire logic       bready,
    input wire logic       arvalid,
    input wire logic       arready,
    input wire logic       rvalid,
    input wire logic       rready,
    input wire logic       dm_re,
    input wire logic       dm_we,
    input wire logic       pm_re,
    input wire logic       io_re,
    input wire logic       io_we,
    input wire logic [5:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // write-back step of a bit set or clear
    sequence s_io_wr;
        io_we && !io_re && $stable(io_addr);
    endsequence
    a_rd_latency: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read answer not one cycle after address");
    a_r_release: assert property (rvalid && rready |=> !rvalid) else $error("rvalid held after take");
    a_b_release: assert property (bvalid && bready |=> !bvalid) else $error("bvalid held after take");
    a_wr_block: assert property (bvalid |-> !awready && !wready) else $error("write taken during response");
    a_dm_read_once: assert property (dm_re |=> !dm_re && !dm_we)
        else $error("data read strobe not single");
    a_dm_write_once: assert property (dm_we |=> !dm_we && !dm_re)
        else $error("data write strobe not single");
    a_pm_read_once: assert property (pm_re |=> !pm_re) else $error("program read strobe not single");
    a_io_rmw_seq: assert property (io_re |=> s_io_wr)
        else $error("io write-back missing after io read");
    a_io_one_bit: assert property (io_we |-> $countones(io_wdata ^ $past(io_rdata)) <= 1)
        else $error("io write-back changed more than one bit");
endmodule : lsb_chk
`default_nettype wire

// [verif/lsb_mem_model.sv]
/* holds: data memory, program memory and io space behind the execution unit.
   assumes: strobes last one cycle; reads answer in the strobe cycle. */
`timescale 1ns/1ns
`default_nettype none
module lsb_mem_model (
    input wire logic        aclk,
    input wire logic [15:0] dm_addr,
    input wire logic        dm_re,
    input wire logic        dm_we,
    input wire logic [7:0]  dm_wdata,
    output logic     [7:0]  dm_rdata,
    input wire logic [15:0] pm_addr,
    input wire logic        pm_re,
    input wire logic        pm_we,
    input wire logic [15:0] pm_wdata,
    output logic     [7:0]  pm_rdata,
    input wire logic [5:0]  io_addr,
    input wire logic        io_re,
    input wire logic        io_we,
    input wire logic [7:0]  io_wdata,
    output logic     [7:0]  io_rdata
);
    logic [7:0]  dm [0:65535];
    logic [7:0]  pm [0:65535];
    logic [7:0]  io [0:63];
    logic [15:0] pm_at;
    logic [15:0] pm_word;
    // unstrobed reads show the inverted byte, never a stale match
    assign dm_rdata = dm_re ? dm[dm_addr] : ~dm[dm_addr];
    assign pm_rdata = pm_re ? pm[pm_addr] : ~pm[pm_addr];
    assign io_rdata = io_re ? io[io_addr] : ~io[io_addr];
    always @(posedge aclk) begin
        if (dm_we) dm[dm_addr] <= dm_wdata;
        if (io_we) io[io_addr] <= io_wdata;
        if (pm_we) pm_at <= pm_addr;
        if (pm_we) pm_word <= pm_wdata;
    end
endmodule : lsb_mem_model
`default_nettype wire

// [verif/load_store_shift_branch_exec_test.sv]
/* holds: self-checking bench driving the unit over AXI4-Lite.
   assumes: design, checker and memory model compiled first. */
`timescale 1ns/1ns
`default_nettype none
module load_store_shift_branch_exec_test;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0]  awaddr = 0, araddr = 0, dm_wdata, dm_rdata, pm_rdata, io_wdata, io_rdata;
    logic [31:0] wdata = 0, rdata, v;
    logic [3:0]  wstrb = 4'hF;
    logic        awready, wready, bvalid, arready, rvalid, dm_re, dm_we, pm_re, pm_we, io_re, io_we;
    logic [1:0]  bresp, rresp, rsp;
    logic [15:0] dm_addr, pm_addr, pm_wdata;
    logic [5:0]  io_addr;
    int          failures = 0, n_checks = 0;
    always #5 aclk = ~aclk;
    lsb_exec_top dut (.*);
    lsb_mem_model mem (.*);
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (bvalid !== 1'b1);
        bready <= 0;
        rsp = bresp;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (rvalid !== 1'b1);
        d = {rdata[31:2], rdata[1:0] | rresp};
        rready <= 0;
    endtask : rd
    task automatic setr(input logic [4:0] i, input logic [7:0] x);
        wr(8'h1C, {27'h0, i});
        wr(8'h20, {24'h0, x});
    endtask : setr
    task automatic gchk(input string nm, input logic [4:0] i, input logic [7:0] e);
        wr(8'h1C, {27'h0, i});
        rd(8'h20, v);
        chk(nm, {24'h0, e}, v);
    endtask : gchk
    task automatic run(input logic [4:0] op, r, input logic [1:0] sel = 2'h0, md = 2'h0,
                       input logic [31:0] oper = 32'h0000_0000);
        wr(8'h08, {18'h0, md, sel, r, op});
        wr(8'h0C, oper);
        wr(8'h00, 32'h0000_0001);
        do rd(8'h04, v); while (v[1] !== 1'b1);
        wr(8'h04, 32'h0000_0002);
    endtask : run
    task automatic t_mem;
        rd(8'h40, v);
        chk("unmapped_read", 32'h0000_0002, v);
        wr(8'h40, 32'h0000_0000);
        chk("unmapped_write", 32'h0000_0002, {30'h0, rsp});
        setr(5'h1C, 8'h10);
        setr(5'h1D, 8'h00);
        chk("bresp_ok", 32'h0000_0000, {30'h0, rsp});
        mem.dm[16'h0010] = 8'hA5;
        run(5'h03, 5'h05, 2'h1, 2'h1);
        gchk("ld_y_inc", 5'h05, 8'hA5);
        gchk("y_inc", 5'h1C, 8'h11);
        setr(5'h1A, 8'h20);
        setr(5'h1B, 8'h00);
        run(5'h06, 5'h05, 2'h0, 2'h2);
        chk("st_x_dec", 32'h0000_00A5, {24'h0, mem.dm[16'h001F]});
        gchk("x_dec", 5'h1A, 8'h1F);
        setr(5'h1E, 8'h40);
        setr(5'h1F, 8'h00);
        mem.dm[16'h007F] = 8'h3C;
        run(5'h04, 5'h07, 2'h2, 2'h0, 32'h0000_003F);
        gchk("ldd_q63", 5'h07, 8'h3C);
        gchk("z_kept", 5'h1E, 8'h40);
        run(5'h08, 5'h07, 2'h0, 2'h0, 32'h0000_0123);
        chk("sts", 32'h0000_003C, {24'h0, mem.dm[16'h0123]});
        run(5'h0C, 5'h07);
        chk("push", 32'h0000_003C, {24'h0, mem.dm[16'h00FF]});
        run(5'h0D, 5'h02);
        gchk("pop", 5'h02, 8'h3C);
        run(5'h05, 5'h03, 2'h0, 2'h0, 32'h0000_0123);
        gchk("lds", 5'h03, 8'h3C);
        run(5'h03, 5'h04, 2'h1, 2'h2);
        gchk("ld_y_dec", 5'h04, 8'hA5);
        run(5'h06, 5'h07, 2'h0, 2'h1);
        chk("st_x_inc", 32'h0000_003C, {24'h0, mem.dm[16'h001F]});
        gchk("x_inc", 5'h1A, 8'h20);
        run(5'h07, 5'h05, 2'h1, 2'h0, 32'h0000_0005);
        chk("std_y_q5", 32'h0000_00A5, {24'h0, mem.dm[16'h0015]});
        $display("t_mem done");
    endtask : t_mem
    task automatic t_io_shift;
        mem.io[5] = 8'h81;
        run(5'h0E, 5'h00, 2'h0, 2'h0, 32'h0000_0305);
        chk("bit_set", 32'h0000_0089, {24'h0, mem.io[5]});
        run(5'h0F, 5'h00, 2'h0, 2'h0, 32'h0000_0705);
        chk("bit_clear", 32'h0000_0009, {24'h0, mem.io[5]});
        wr(8'h14, 32'h0000_0001);
        setr(5'h09, 8'h80);
        run(5'h12, 5'h09);
        gchk("rol", 5'h09, 8'h01);
        rd(8'h14, v);
        chk("rol_flags", 32'h0000_0009, v);
        run(5'h11, 5'h09);
        gchk("lsr", 5'h09, 8'h00);
        rd(8'h14, v);
        chk("lsr_flags", 32'h0000_000B, v);
        run(5'h13, 5'h09);
        gchk("ror", 5'h09, 8'h80);
        rd(8'h14, v);
        chk("ror_flags", 32'h0000_000C, v);
        run(5'h10, 5'h09);
        gchk("lsl", 5'h09, 8'h00);
        $display("t_io_shift done");
    endtask : t_io_shift
    task automatic t_branch_prog;
        wr(8'h14, 32'h0000_0000);
        wr(8'h10, 32'h0000_0010);
        run(5'h00, 5'h00, 2'h0, 2'h0, 32'h0000_0005);
        chk("bnv_len", 32'h0000_0002, {28'h0, v[11:8]});
        rd(8'h10, v);
        chk("bnv_pc", 32'h0000_0016, v);
        run(5'h01, 5'h00, 2'h0, 2'h0, 32'h0000_0005);
        chk("bie_len", 32'h0000_0001, {28'h0, v[11:8]});
        rd(8'h10, v);
        chk("bie_pc", 32'h0000_0017, v);
        run(5'h02, 5'h00, 2'h0, 2'h0, 32'h0000_0003);
        rd(8'h10, v);
        chk("bid_pc", 32'h0000_001B, v);
        mem.pm[16'h0040] = 8'h5A;
        run(5'h09, 5'h00);
        gchk("lpm_r0", 5'h00, 8'h5A);
        setr(5'h01, 8'h12);
        run(5'h0B, 5'h00);
        chk("spm", 32'h0040_125A, {mem.pm_at, mem.pm_word});
        run(5'h0A, 5'h06, 2'h0, 2'h1);
        gchk("lpm_rd", 5'h06, 8'h5A);
        gchk("z_lpm_inc", 5'h1E, 8'h41);
        $display("t_branch_prog done");
    endtask : t_branch_prog
    task automatic print_verdict;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        t_mem;
        t_io_shift;
        t_branch_prog;
        print_verdict;
    end
    initial begin
        #300000;
        failures++;
        print_verdict;
    end
endmodule : load_store_shift_branch_exec_test
bind lsb_exec_top lsb_chk u_chk (.*);
`default_nettype wire
